/* File: txlen_pkg.sv */
// package: constants for the transmit length low register block
`default_nettype none
package txlen_pkg;
  // ==========================================================
  // register map
  localparam logic [4:0] TXLEN_HI_ADDR = 5'h1D;
  localparam logic [4:0] TXLEN_LO_ADDR = 5'h1E;
  localparam logic [7:0] TXLEN_LO_RESET = 8'h00;
  localparam logic [7:0] TXLEN_HI_RESET = 8'h00;
  // ==========================================================
  // field positions in the low byte
  localparam int COUNT_LO_MSB = 7;
  localparam int COUNT_LO_LSB = 4;
  localparam int PARTIAL_MSB = 3;
  localparam int PARTIAL_LSB = 1;
  localparam int PARTIAL_FLAG = 0;
  // ==========================================================
  // widths
  localparam int COUNT_W = 12;
  localparam int PBITS_W = 3;
endpackage : txlen_pkg
`default_nettype wire

/* File: txlen_field.sv */
// module: decodes the low length byte into count nibble and partial-byte fields
`timescale 1ns/1ns
`default_nettype none
module txlen_field (
  // raw register
  input wire logic [7:0] reg_val_i,
  // decoded fields
  output logic [3:0] count_lo_o,
  output logic [2:0] partial_bits_o,
  output logic partial_flag_o
);
  // ==========================================================
  // field extraction
  assign count_lo_o = reg_val_i[txlen_pkg::COUNT_LO_MSB:txlen_pkg::COUNT_LO_LSB];
  assign partial_bits_o = reg_val_i[txlen_pkg::PARTIAL_MSB:txlen_pkg::PARTIAL_LSB];
  assign partial_flag_o = reg_val_i[txlen_pkg::PARTIAL_FLAG];
endmodule : txlen_field
`default_nettype wire

/* File: txlen_lo_reg.sv */
// module: transmit length low register with its companion high byte and length outputs
// How it works
// - zero at reset or chip disabled
// - clear at end of transmit frame
// - bits 7..4 are count bits 3..0
// - bits 3..1 are partial bit count
// - partial count used only when flagged
// - bit 0 marks short last byte
// - companion byte gives count bits 11..4
`timescale 1ns/1ns
`default_nettype none
module txlen_lo_reg (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // chip enable and frame end
  input wire logic chip_en_i,
  input wire logic tx_eof_i,
  // register port
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // length seen by the transmitter
  output logic [11:0] tx_byte_count_o,
  output logic [2:0] tx_last_bits_o,
  output logic tx_partial_o
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] rdata;
  } txlen_state_t;

  txlen_state_t st;
  txlen_state_t next_st;
  logic [3:0] count_lo;
  logic [2:0] partial_bits;
  logic partial_flag;

  txlen_field u_field (
    .reg_val_i(st.lo),
    .count_lo_o(count_lo),
    .partial_bits_o(partial_bits),
    .partial_flag_o(partial_flag)
  );

  // ==========================================================
  // address decode
  // one map for both write strobes, so the two bytes never disagree on it
  function automatic logic addr_is(input logic [4:0] addr, input logic [4:0] target);
    addr_is = (addr == target);
  endfunction : addr_is

  // ==========================================================
  // write strobes
  logic wr_lo;
  logic wr_hi;

  assign wr_lo = reg_wr_i && addr_is(reg_addr_i, txlen_pkg::TXLEN_LO_ADDR);
  assign wr_hi = reg_wr_i && addr_is(reg_addr_i, txlen_pkg::TXLEN_HI_ADDR);

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    if (wr_lo) begin
      next_st.lo = reg_wdata_i;
    end
    if (wr_hi) begin
      next_st.hi = reg_wdata_i;
    end
    // frame end wins over a write in the same cycle so no stale length survives
    if (tx_eof_i) begin
      next_st.lo = txlen_pkg::TXLEN_LO_RESET;
      next_st.hi = txlen_pkg::TXLEN_HI_RESET;
    end
    if (!chip_en_i) begin
      next_st.lo = txlen_pkg::TXLEN_LO_RESET;
      next_st.hi = txlen_pkg::TXLEN_HI_RESET;
    end
    unique case (reg_addr_i)
      txlen_pkg::TXLEN_LO_ADDR: next_st.rdata = st.lo;
      txlen_pkg::TXLEN_HI_ADDR: next_st.rdata = st.hi;
      default: next_st.rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st <= '{lo: txlen_pkg::TXLEN_LO_RESET, hi: txlen_pkg::TXLEN_HI_RESET, rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign reg_rdata_o = st.rdata;
  assign tx_byte_count_o = {st.hi, count_lo};
  assign tx_partial_o = partial_flag;
  assign tx_last_bits_o = partial_flag ? partial_bits : 3'h0;

  // ==========================================================
  // check sequences
  // antecedents read the pins, not the internal strobes, so a broken decode cannot hide itself
  sequence quiet_s;
    !reg_wr_i && chip_en_i && !tx_eof_i;
  endsequence

  sequence wr_lo_s;
    reg_wr_i && reg_addr_i == txlen_pkg::TXLEN_LO_ADDR && chip_en_i && !tx_eof_i;
  endsequence

  sequence wr_hi_s;
    reg_wr_i && reg_addr_i == txlen_pkg::TXLEN_HI_ADDR && chip_en_i && !tx_eof_i;
  endsequence

  // host paces its writes with one idle cycle between them
  sequence wr_pair_s;
    wr_hi_s ##1 quiet_s ##1 wr_lo_s;
  endsequence

  // clears excluded, so the only way to move a byte is a write to it
  sequence no_lo_change_s;
    !(reg_wr_i && reg_addr_i == txlen_pkg::TXLEN_LO_ADDR) && chip_en_i && !tx_eof_i;
  endsequence

  sequence no_hi_change_s;
    !(reg_wr_i && reg_addr_i == txlen_pkg::TXLEN_HI_ADDR) && chip_en_i && !tx_eof_i;
  endsequence

  // ==========================================================
  // checks: reset and chip enable
  reset_zero_a: assert property (@(posedge clk_sys_i) sys_rst_i |=> st.lo == 8'h00 && st.hi == 8'h00)
    else $error("length not zero after reset");

  reset_out_a: assert property (@(posedge clk_sys_i)
    sys_rst_i |=> tx_byte_count_o == 12'h000 && tx_last_bits_o == 3'h0 && !tx_partial_o && reg_rdata_o == 8'h00)
    else $error("outputs not zero after reset");

  disable_zero_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !chip_en_i |=> st.lo == 8'h00 && tx_byte_count_o == 12'h000)
    else $error("length not zero while disabled");

  disable_wins_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !chip_en_i && reg_wr_i |=> st.lo == 8'h00 && st.hi == 8'h00)
    else $error("write taken while disabled");

  // ==========================================================
  // checks: frame end
  eof_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_eof_i |=> st.lo == 8'h00 && !tx_partial_o)
    else $error("length not cleared at frame end");

  eof_high_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_eof_i |=> tx_byte_count_o == 12'h000 && tx_last_bits_o == 3'h0)
    else $error("count not cleared at frame end");

  eof_wins_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tx_eof_i && reg_wr_i |=> st.lo == 8'h00 && st.hi == 8'h00)
    else $error("write taken at frame end");

  // ==========================================================
  // checks: low byte fields
  count_low_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo_s |=> tx_byte_count_o[3:0] == $past(reg_wdata_i[7:4]))
    else $error("low count nibble wrong");

  hold_low_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    no_lo_change_s |=> $stable(st.lo))
    else $error("low byte changed without a write");

  partial_count_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo_s ##0 reg_wdata_i[0] |=> tx_last_bits_o == $past(reg_wdata_i[3:1]))
    else $error("partial bit count wrong");

  partial_gate_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !tx_partial_o |-> tx_last_bits_o == 3'h0)
    else $error("partial count used without flag");

  partial_hide_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo_s ##0 !reg_wdata_i[0] |=> tx_last_bits_o == 3'h0)
    else $error("partial count shown without flag");

  partial_flag_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_lo_s |=> tx_partial_o == $past(reg_wdata_i[0]))
    else $error("partial flag wrong");

  // ==========================================================
  // checks: high byte and full length
  count_high_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_hi_s |=> tx_byte_count_o[11:4] == $past(reg_wdata_i))
    else $error("high count bits wrong");

  hold_high_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    no_hi_change_s |=> $stable(st.hi))
    else $error("high byte changed without a write");

  full_count_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_pair_s |=> tx_byte_count_o == {$past(reg_wdata_i, 3), $past(reg_wdata_i[7:4])})
    else $error("full byte count wrong");

  full_bits_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_pair_s |=> tx_last_bits_o == ($past(reg_wdata_i[0]) ? $past(reg_wdata_i[3:1]) : 3'h0))
    else $error("final partial bits wrong");

  // ==========================================================
  // checks: read back
  read_back_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_addr_i == txlen_pkg::TXLEN_LO_ADDR |=> reg_rdata_o == $past(st.lo))
    else $error("read back wrong");

  read_high_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    reg_addr_i == txlen_pkg::TXLEN_HI_ADDR |=> reg_rdata_o == $past(st.hi))
    else $error("high byte read back wrong");
endmodule : txlen_lo_reg
`default_nettype wire

/* File: txlen_host.sv */
// host model driving the register port
`timescale 1ns/1ns
`default_nettype none
module txlen_host (
  // register port
  input wire logic clk_sys_i,
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o
);
  initial begin
    reg_addr_o = 5'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // one-cycle strobe; data lines scrambled after so stale data never looks valid
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_wr_o = 1'b1;
    reg_wdata_o = d;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask : wr
endmodule : txlen_host
`default_nettype wire

/* File: tx_length_low_register_bench.sv */
// self-checking bench for the transmit length low register
`timescale 1ns/1ns
`default_nettype none
module tx_length_low_register_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic eof = 1'b0;
  wire [4:0] addr;
  wire wr;
  wire [7:0] wd;
  wire [7:0] rd;
  wire [11:0] cnt;
  wire [2:0] bits;
  wire flag;
  wire [23:0] obs = {rd, cnt, bits, flag};
  int n_mismatch = 0;
  int n_checks = 0;
  // rows: high byte, low byte, then {read data, count, bits, flag}
  logic [39:0] rows [4] = '{40'h005B5B005B, 40'hABF0F0ABF0, 40'hFFFEFEFFF0, 40'h120F0F120F};
  txlen_host txlen_host_inst (.clk_sys_i(clk), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wd));
  txlen_lo_reg txlen_lo_reg_inst (.clk_sys_i(clk), .sys_rst_i(rst), .chip_en_i(en), .tx_eof_i(eof),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rd),
    .tx_byte_count_o(cnt), .tx_last_bits_o(bits), .tx_partial_o(flag));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk(obs, 24'h0);
    foreach (rows[i]) begin
      txlen_host_inst.wr(5'h1D, rows[i][39:32]);
      txlen_host_inst.wr(5'h1E, rows[i][31:24]);
      @(negedge clk);
      chk(obs, rows[i][23:0]);
    end
    txlen_host_inst.wr(5'h1F, 8'hAA);
    @(negedge clk);
    chk(obs, 24'h00120F);
    txlen_host_inst.wr(5'h1E, 8'h5B);
    @(negedge clk);
    eof = 1'b1;
    @(negedge clk);
    eof = 1'b0;
    @(negedge clk);
    chk(obs, 24'h0);
    txlen_host_inst.wr(5'h1D, 8'h34);
    en = 1'b0;
    txlen_host_inst.wr(5'h1E, 8'h5B);
    en = 1'b1;
    @(negedge clk);
    chk(obs, 24'h0);
    // reset again in mid-run, then write one idle cycle after release
    txlen_host_inst.wr(5'h1E, 8'h5B);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk(obs, 24'h0);
    txlen_host_inst.wr(5'h1E, 8'hA3);
    txlen_host_inst.wr(5'h1D, 8'h34);
    @(negedge clk);
    chk(obs, 24'h3434A3);
    // frame end in the very cycle of a write: the clear wins
    fork
      txlen_host_inst.wr(5'h1E, 8'hFF);
      begin
        @(negedge clk);
        eof = 1'b1;
        @(negedge clk);
        eof = 1'b0;
      end
    join
    @(negedge clk);
    chk(obs, 24'h0);
    finish_test();
  end
  // run needs well under 100 cycles
  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end
endmodule : tx_length_low_register_bench
`default_nettype wire
